/* File: core/tsx_core.sv */
// tsx_core: executes one issued instruction word in four quarter-phases per cycle
// assumes an Avalon-MM master on the same clock; words come in through INSTR
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module tsx_core import tsx_pkg::*; #(
  parameter int unsigned Q_DIV = 1,
  parameter int unsigned MEM_DEPTH = 16
) (
  input wire logic clk, // core clock, 40 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic [AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic busy // instruction in flight
);
  localparam int unsigned MW = $clog2(MEM_DEPTH);

  tsx_state_t st_q;
  tsx_dec_t dec;
  logic [7:0] qdiv_q;
  logic qe;
  logic [1:0] qph_q;
  logic [1:0] cyc_q;
  logic [1:0] nc_q;
  logic [1:0] ncyc;
  logic [1:0] skw;
  logic [1:0] tgt;
  logic q4;
  logic q4_first;
  logic fin;
  logic start;
  logic wacc;
  logic rv_q;
  logic [31:0] rd_q;
  logic [31:0] rmux;
  logic [31:0] bmask;
  logic [31:0] wm;
  logic ext_q;
  logic [3:0] bsr_q;
  logic [15:0] ins_q;
  logic [15:0] nxt_q;
  logic [MW-1:0] fa_q;
  logic [7:0] w_q;
  logic flag_n_q;
  logic flag_z_q;
  logic skip_q;
  logic bad_q;
  logic [11:0] fsr_q [3];
  logic [21:0] table_pointer_q;
  logic [7:0] table_latch_q;
  logic [7:0] hold_q [HOLD_N];
  logic [7:0] mem_q [MEM_DEPTH];
  logic [20:0] pc_q;
  logic [20:0] tos_q;
  logic [11:0] ea;
  logic [11:0] idx_ea;
  logic [MW-1:0] idx_i;
  logic [MW-1:0] bank_i;
  logic [7:0] fval;
  logic [7:0] xres;
  logic zero;
  logic tw;
  logic ret;
  logic [1:0] pi;
  logic [2:0] hidx;

  function automatic logic two_word(logic [15:0] i, logic x);
    two_word = i[15:12] == OPC_MOVFF || i[15:9] == OPC_CALL ||
               i[15:8] == OPC_LFSR || i[15:8] == OPC_GOTO ||
               (x && i[15:8] == OPC_MOVS);
  endfunction : two_word

  // quarter-phase enable; Q_DIV stretches a phase for slow benches
  assign qe = (qdiv_q == 8'(Q_DIV - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qdiv_q <= 8'h00;
    end else if (qe) begin
      qdiv_q <= 8'h00;
    end else begin
      qdiv_q <= qdiv_q + 8'h01;
    end
  end

  // bus slave: writes wait while an instruction runs, reads take one wait cycle
  assign busy = (st_q == ST_EXEC);
  assign wacc = avs_write && !busy;
  assign start = wacc && avs_address == OFF_INSTR;
  assign avs_waitrequest = (avs_read && !rv_q) || (avs_write && busy);
  assign avs_readdata = rd_q;
  assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wm = (rmux & ~bmask) | (avs_writedata & bmask);

  always_comb begin
    rmux = 32'h0000_0000;
    if (avs_address >= OFF_HOLD && avs_address < OFF_HOLD + 8'(4 * HOLD_N)) begin
      rmux[7:0] = hold_q[avs_address[4:2]];
    end else begin
      unique case (avs_address)
        OFF_CTRL: rmux[0] = ext_q;
        OFF_INSTR: rmux[15:0] = ins_q;
        OFF_NEXT: rmux[15:0] = nxt_q;
        OFF_WREG: rmux[7:0] = w_q;
        OFF_STAT: begin
          rmux[SB_Z] = flag_z_q;
          rmux[SB_N] = flag_n_q;
          rmux[SB_BUSY] = busy;
          rmux[SB_SKIP] = skip_q;
          rmux[SB_BAD] = bad_q;
          rmux[SB_CYC +: 2] = nc_q;
        end
        OFF_BSR: rmux[3:0] = bsr_q;
        OFF_FSR0: rmux[11:0] = fsr_q[0];
        OFF_FSR1: rmux[11:0] = fsr_q[1];
        OFF_THIRD_POINTER_REG: rmux[11:0] = fsr_q[2];
        OFF_TPTR: rmux[21:0] = table_pointer_q;
        OFF_TLAT: rmux[7:0] = table_latch_q;
        OFF_FADR: rmux[MW-1:0] = fa_q;
        OFF_FDAT: rmux[7:0] = mem_q[fa_q];
        OFF_TOS: rmux[20:0] = tos_q;
        OFF_PC: rmux[20:0] = pc_q;
        default: rmux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      rv_q <= avs_read && !rv_q;
      if (avs_read && !rv_q) begin
        rd_q <= rmux;
      end
    end
  end

  // decode; extended opcodes only exist while the extended set is on
  always_comb begin
    dec = '0;
    dec.op = OP_BAD;
    dec.a = ins_q[8];
    dec.d = ins_q[9];
    dec.f = ins_q[7:0];
    dec.ptr = ins_q[7:6];
    dec.k6 = ins_q[5:0];
    if (ins_q[15:9] == OPC_TST) begin
      dec.op = OP_TST;
    end else if (ins_q[15:10] == OPC_XOR_WORK_WITH_REG) begin
      dec.op = OP_XOR_WORK_WITH_REG;
    end else if (ins_q[15:8] == OPC_XOR_LITERAL_TO_WORK) begin
      dec.op = OP_XOR_LITERAL_TO_WORK;
    end else if (ins_q[15:8] == OPC_ADDF && ext_q) begin
      dec.op = OP_ADDF;
    end else if (ins_q[15:8] == OPC_SUBF && ext_q) begin
      dec.op = OP_SUBF;
    end else if (ins_q[15:2] == OPC_TABLE_WRITE_OP) begin
      dec.op = OP_TABLE_WRITE_OP;
    end else if (ins_q == 16'h0000) begin
      dec.op = OP_NOP;
    end
  end

  // file address; memory is small, so upper address bits alias
  assign idx_ea = fsr_q[2] + {4'h0, dec.f};
  assign idx_i = idx_ea[MW-1:0];
  assign bank_i = dec.f[MW-1:0];
  always_comb begin
    if (dec.a) begin
      ea = {bsr_q, dec.f};
    end else if (ext_q && dec.f <= IDX_MAX) begin
      ea = idx_ea;
    end else if (dec.f <= IDX_MAX) begin
      ea = {4'h0, dec.f};
    end else begin
      ea = {4'hF, dec.f};
    end
  end
  assign fval = mem_q[ea[MW-1:0]];
  assign xres = w_q ^ (dec.op == OP_XOR_LITERAL_TO_WORK ? dec.f : fval);
  assign zero = (fval == 8'h00);
  assign tw = two_word(nxt_q, ext_q);
  assign ret = (dec.op == OP_ADDF || dec.op == OP_SUBF) && dec.ptr == PTR_RET;
  assign pi = ret ? 2'h2 : dec.ptr;
  assign hidx = (ins_q[1:0] == TB_PREINC) ? table_pointer_q[2:0] + 3'h1 : table_pointer_q[2:0];

  // skipped words become no-op cycles; nonzero test runs in one cycle
  assign skw = (dec.op == OP_TST && zero) ? (tw ? 2'h2 : 2'h1) : 2'h0;
  assign ncyc = (dec.op == OP_TABLE_WRITE_OP || ret) ? 2'h2 : 2'h1 + skw;
  assign q4 = busy && qe && qph_q == Q4;
  assign q4_first = q4 && cyc_q == 2'h0;
  assign tgt = (cyc_q == 2'h0) ? ncyc : nc_q;
  assign fin = q4 && (cyc_q + 2'h1 == tgt);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      qph_q <= 2'h0;
      cyc_q <= 2'h0;
      nc_q <= 2'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_EXEC;
            qph_q <= 2'h0;
            cyc_q <= 2'h0;
          end
        end
        ST_EXEC: begin
          if (qe) begin
            qph_q <= qph_q + 2'h1;
            if (q4_first) begin
              nc_q <= ncyc;
            end
            if (fin) begin
              st_q <= ST_IDLE;
            end else if (qph_q == Q4) begin
              cyc_q <= cyc_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // control and instruction words
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_q <= CTRL_EXT_RST;
      bsr_q <= 4'h0;
      ins_q <= 16'h0000;
      nxt_q <= 16'h0000;
      fa_q <= '0;
    end else if (wacc) begin
      if (avs_address == OFF_CTRL) ext_q <= wm[0];
      if (avs_address == OFF_BSR) bsr_q <= wm[3:0];
      if (avs_address == OFF_INSTR) ins_q <= wm[15:0];
      if (avs_address == OFF_NEXT) nxt_q <= wm[15:0];
      if (avs_address == OFF_FADR) fa_q <= wm[MW-1:0];
    end
  end

  // work register and flags; the test instruction leaves flags alone
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_q <= 8'h00;
      flag_n_q <= 1'b0;
      flag_z_q <= 1'b0;
      skip_q <= 1'b0;
      bad_q <= 1'b0;
    end else if (wacc && avs_address == OFF_WREG) begin
      w_q <= wm[7:0];
    end else if (q4_first) begin
      skip_q <= (skw != 2'h0);
      bad_q <= (dec.op == OP_BAD);
      if (dec.op == OP_XOR_LITERAL_TO_WORK || dec.op == OP_XOR_WORK_WITH_REG) begin
        flag_n_q <= xres[7];
        flag_z_q <= (xres == 8'h00);
        if (dec.op == OP_XOR_LITERAL_TO_WORK || !dec.d) begin
          w_q <= xres;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_DEPTH; i++) mem_q[i] <= 8'h00;
    end else if (wacc && avs_address == OFF_FDAT) begin
      mem_q[fa_q] <= wm[7:0];
    end else if (q4_first && dec.op == OP_XOR_WORK_WITH_REG && dec.d) begin
      mem_q[ea[MW-1:0]] <= xres;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) fsr_q[i] <= 12'h000;
    end else if (wacc && avs_address == OFF_FSR0) begin
      fsr_q[0] <= wm[11:0];
    end else if (wacc && avs_address == OFF_FSR1) begin
      fsr_q[1] <= wm[11:0];
    end else if (wacc && avs_address == OFF_THIRD_POINTER_REG) begin
      fsr_q[2] <= wm[11:0];
    end else if (q4_first && dec.op == OP_ADDF) begin
      fsr_q[pi] <= fsr_q[pi] + {6'h00, dec.k6};
    end else if (q4_first && dec.op == OP_SUBF) begin
      fsr_q[pi] <= fsr_q[pi] - {6'h00, dec.k6};
    end
  end

  // table write: pointer low bits pick the holding register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      table_pointer_q <= 22'h00_0000;
      table_latch_q <= 8'h00;
      for (int i = 0; i < HOLD_N; i++) hold_q[i] <= 8'h00;
    end else if (wacc && avs_address == OFF_TPTR) begin
      table_pointer_q <= wm[21:0];
    end else if (wacc && avs_address == OFF_TLAT) begin
      table_latch_q <= wm[7:0];
    end else if (q4_first && dec.op == OP_TABLE_WRITE_OP) begin
      hold_q[hidx] <= table_latch_q;
      if (ins_q[1:0] == TB_POSTINC || ins_q[1:0] == TB_PREINC) begin
        table_pointer_q <= table_pointer_q + 22'h00_0001;
      end else if (ins_q[1:0] == TB_POSTDEC) begin
        table_pointer_q <= table_pointer_q - 22'h00_0001;
      end
    end
  end

  // program counter steps two bytes per word, skipped words included
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= 21'h00_0000;
      tos_q <= 21'h00_0000;
    end else if (wacc && avs_address == OFF_TOS) begin
      tos_q <= wm[20:0];
    end else if (fin && ret && cyc_q != 2'h0) begin
      pc_q <= tos_q;
    end else if (q4_first) begin
      pc_q <= pc_q + {18'h0_0000, skw, 1'b0} + 21'h00_0002;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_first(tsx_op_t o);
    q4_first && dec.op == o;
  endsequence

  sequence s_done_at(logic [1:0] c);
    fin && cyc_q == c;
  endsequence

  a_tst_flags_kept: assert property (s_first(OP_TST) |=>
    flag_n_q == $past(flag_n_q) && flag_z_q == $past(flag_z_q))
    else $error("test-and-skip changed a flag");
  a_skip_two_cyc: assert property ((fin && dec.op == OP_TST && zero && !tw) |->
    cyc_q == 2'h1) else $error("skip over one word did not take two cycles");
  a_skip_three_cyc: assert property ((fin && dec.op == OP_TST && zero && tw) |->
    s_done_at(2'h2)) else $error("skip over two words did not take three cycles");
  a_tst_no_skip: assert property (s_first(OP_TST) ##0 !zero |-> fin ##1
    (pc_q == $past(pc_q) + 21'h00_0002 && !busy))
    else $error("nonzero test did not finish in one cycle");
  a_bank_sel_wr: assert property (s_first(OP_XOR_WORK_WITH_REG) ##0 (dec.d && dec.a) |=>
    mem_q[$past(bank_i)] == $past(xres)) else $error("banked write went astray");
  a_idx_mode_wr: assert property (s_first(OP_XOR_WORK_WITH_REG) ##0
    (dec.d && !dec.a && ext_q && dec.f <= IDX_MAX) |=> mem_q[$past(idx_i)] == $past(xres))
    else $error("indexed literal offset write went astray");
  a_xor_literal_to_work_result: assert property (s_first(OP_XOR_LITERAL_TO_WORK) |-> fin ##1
    (w_q == $past(xres) && flag_z_q == (w_q == 8'h00) && flag_n_q == w_q[7]))
    else $error("xor literal result or flags wrong");
  a_xor_work_with_reg_dest: assert property (s_first(OP_XOR_WORK_WITH_REG) ##0 !dec.d |-> fin ##1
    w_q == $past(xres)) else $error("xor register result not in work register");
  a_xor_work_with_reg_flags: assert property (s_first(OP_XOR_WORK_WITH_REG) |=>
    flag_z_q == ($past(xres) == 8'h00) && flag_n_q == $past(xres[7]))
    else $error("xor register flags wrong");
  a_ulnk_return: assert property ((fin && ret) |-> cyc_q == 2'h1 ##1
    pc_q == $past(tos_q)) else $error("pointer return variant did not return");
  a_table_write_op_hold: assert property (s_first(OP_TABLE_WRITE_OP) |=>
    hold_q[$past(hidx)] == $past(table_latch_q)) else $error("holding register not written");
  a_ext_gate: assert property ((q4_first && !ext_q && ins_q[15:9] == OPC_ADDF[7:1]) |=>
    bad_q && fsr_q[2] == $past(fsr_q[2])) else $error("extended op ran while disabled");
endmodule : tsx_core

/* File: core/tsx_pkg.sv */
// tsx_pkg: constants and types for the test-skip / xor / extended-set executor
// assumes a single 40 MHz core clock and an Avalon-MM slave with 32-bit data
// Summary of operation
// - test-and-skip opcode 0110 011a ffff ffff; status flags stay unchanged
// - tested register zero: prefetched word dropped, a no-op cycle follows
// - skip over a two-word instruction makes the test take three cycles
// - access bit 0 picks the access bank, 1 picks bank select register
// - access 0, extended set on, field at most 95: indexed literal offset
// - xor literal into work register, sets negative and zero, one cycle
// - xor work with register; destination 0 to work, 1 back to register
// - xor register opcode 0001 10da ffff ffff, sets negative and zero, one cycle
// - extended set adds pointer instructions and indexed literal offset mode
// - extended set enabled after reset; a configuration bit turns it off
// - extended instructions adjust a pointer register or index from one
// - pointer add/subtract with pointer field 3 on the third pointer returns from subroutine after
// - table write stores latch byte in holding register picked by pointer[2:0]
package tsx_pkg;
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_NEXT = 8'h08;
  localparam logic [7:0] OFF_WREG = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_BSR = 8'h14;
  localparam logic [7:0] OFF_FSR0 = 8'h18;
  localparam logic [7:0] OFF_FSR1 = 8'h1C;
  localparam logic [7:0] OFF_THIRD_POINTER_REG = 8'h20;
  localparam logic [7:0] OFF_TPTR = 8'h24;
  localparam logic [7:0] OFF_TLAT = 8'h28;
  localparam logic [7:0] OFF_FADR = 8'h2C;
  localparam logic [7:0] OFF_FDAT = 8'h30;
  localparam logic [7:0] OFF_TOS = 8'h34;
  localparam logic [7:0] OFF_PC = 8'h38;
  localparam logic [7:0] OFF_HOLD = 8'h40;
  localparam int unsigned HOLD_N = 8;
  localparam logic CTRL_EXT_RST = 1'b1;
  localparam int unsigned SB_Z = 0;
  localparam int unsigned SB_N = 1;
  localparam int unsigned SB_BUSY = 4;
  localparam int unsigned SB_SKIP = 5;
  localparam int unsigned SB_BAD = 6;
  localparam int unsigned SB_CYC = 8;
  localparam logic [6:0] OPC_TST = 7'h33;
  localparam logic [5:0] OPC_XOR_WORK_WITH_REG = 6'h06;
  localparam logic [7:0] OPC_XOR_LITERAL_TO_WORK = 8'h0A;
  localparam logic [7:0] OPC_ADDF = 8'hE8;
  localparam logic [7:0] OPC_SUBF = 8'hE9;
  localparam logic [13:0] OPC_TABLE_WRITE_OP = 14'h0003;
  localparam logic [3:0] OPC_MOVFF = 4'hC;
  localparam logic [6:0] OPC_CALL = 7'h76;
  localparam logic [7:0] OPC_LFSR = 8'hEE;
  localparam logic [7:0] OPC_GOTO = 8'hEF;
  localparam logic [7:0] OPC_MOVS = 8'hEB;
  localparam logic [7:0] IDX_MAX = 8'h5F;
  localparam logic [1:0] PTR_RET = 2'h3;
  localparam logic [1:0] TB_PREINC = 2'h3;
  localparam logic [1:0] TB_POSTINC = 2'h1;
  localparam logic [1:0] TB_POSTDEC = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_XOR_LITERAL_TO_WORK = 3'h1,
    OP_XOR_WORK_WITH_REG = 3'h2,
    OP_TST = 3'h3,
    OP_ADDF = 3'h4,
    OP_SUBF = 3'h5,
    OP_TABLE_WRITE_OP = 3'h6,
    OP_BAD = 3'h7
  } tsx_op_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } tsx_state_t;
  typedef struct packed {
    tsx_op_t op;
    logic a;
    logic d;
    logic [7:0] f;
    logic [1:0] ptr;
    logic [5:0] k6;
  } tsx_dec_t;
endpackage : tsx_pkg

/* File: sim/tsx_core_tb_top.sv */
// tsx_core_tb_top: self-checking bench for the test-skip / xor / extended-set executor
// assumes tsx_pkg and tsx_core compiled first; the bench is the only Avalon-MM master
`timescale 1ns/1ps
module tsx_core_tb_top import tsx_pkg::*;;
  localparam int unsigned QD = 1;
  logic clk;
  logic rst_b;
  logic [AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  int bad_count;
  int comparisons;

  tsx_core #(.Q_DIV(QD), .MEM_DEPTH(16)) dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  task automatic chk_cyc(input string nm, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_cyc

  // every request starts one edge after the last release, so no signal is set twice in a step
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    avs_write <= 1'b0;
    if (n >= 1000) chk_cyc("write wait", 0, n);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    d = avs_readdata;
    avs_read <= 1'b0;
    if (n >= 1000) chk_cyc("read wait", 0, n);
  endtask : bus_read

  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus_read(a, v);
    chk_val(nm, exp, v);
  endtask : chk_reg

  // busy must stand for four quarter phases of QD clocks per instruction cycle
  task automatic run_op(input logic [15:0] ins, input logic [15:0] nxt, input int ncyc);
    int n;
    bus_write(OFF_NEXT, {16'h0000, nxt});
    bus_write(OFF_INSTR, {16'h0000, ins});
    n = 0;
    do begin
      @(posedge clk);
      if (busy === 1'b1) n++;
    end while (busy !== 1'b0 && n < 100);
    chk_cyc("busy clocks", 4 * QD * ncyc, n);
  endtask : run_op

  function automatic logic [31:0] stat(input int cyc, input bit sk, input bit bd,
                                       input bit n, input bit z);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[SB_CYC +: 2] = cyc[1:0];
    r[SB_SKIP] = sk;
    r[SB_BAD] = bd;
    r[SB_N] = n;
    r[SB_Z] = z;
    return r;
  endfunction : stat

  task automatic set_mem(input logic [7:0] a, input logic [7:0] v);
    bus_write(OFF_FADR, {24'h0000_00, a});
    bus_write(OFF_FDAT, {24'h0000_00, v});
  endtask : set_mem

  task automatic t_reset;
    chk_reg("ctrl", OFF_CTRL, 32'h0000_0001);
    chk_reg("stat", OFF_STAT, 32'h0000_0000);
    bus_write(8'h3C, 32'hFFFF_FFFF);
    chk_reg("unmapped", 8'h3C, 32'h0000_0000);
    // only the low lane may change when one byte enable is set
    bus_write(OFF_FSR0, 32'h0000_0ABC);
    avs_byteenable <= 4'h1;
    bus_write(OFF_FSR0, 32'hFFFF_FF55);
    avs_byteenable <= 4'hF;
    chk_reg("fsr0 lanes", OFF_FSR0, 32'h0000_0A55);
    $display("test reset done");
  endtask : t_reset

  task automatic t_xor_literal_to_work;
    bus_write(OFF_WREG, 32'h0000_00B5);
    run_op(16'h0AAF, 16'h0000, 1);
    chk_reg("w", OFF_WREG, 32'h0000_001A);
    chk_reg("stat", OFF_STAT, stat(1, 0, 0, 0, 0));
    run_op(16'h0A1A, 16'h0000, 1);
    chk_reg("stat", OFF_STAT, stat(1, 0, 0, 0, 1));
    run_op(16'h0A80, 16'h0000, 1);
    chk_reg("w", OFF_WREG, 32'h0000_0080);
    chk_reg("stat", OFF_STAT, stat(1, 0, 0, 1, 0));
    $display("test xor literal done");
  endtask : t_xor_literal_to_work

  task automatic t_xor_work_with_reg;
    logic [31:0] v;
    set_mem(8'h08, 8'hAF);
    set_mem(8'h03, 8'h35);
    bus_write(OFF_THIRD_POINTER_REG, 32'h0000_0005);
    bus_write(OFF_WREG, 32'h0000_00B5);
    run_op(16'h1A03, 16'h0000, 1);
    bus_write(OFF_FADR, 32'h0000_0008);
    chk_reg("indexed f", OFF_FDAT, 32'h0000_001A);
    chk_reg("w kept", OFF_WREG, 32'h0000_00B5);
    bus_write(OFF_CTRL, 32'h0000_0000);
    run_op(16'h1803, 16'h0000, 1);
    chk_reg("w", OFF_WREG, 32'h0000_0080);
    chk_reg("stat", OFF_STAT, stat(1, 0, 0, 1, 0));
    bus_write(OFF_FADR, 32'h0000_0003);
    chk_reg("access f", OFF_FDAT, 32'h0000_0035);
    set_mem(8'h02, 8'h80);
    bus_write(OFF_BSR, 32'h0000_0001);
    run_op(16'h1902, 16'h0000, 1);
    chk_reg("stat", OFF_STAT, stat(1, 0, 0, 0, 1));
    bus_read(OFF_WREG, v);
    chk_val("w zero", 32'h0000_0000, v);
    bus_write(OFF_WREG, 32'h0000_000F);
    run_op(16'h1B02, 16'h0000, 1);
    chk_reg("banked f", OFF_FDAT, 32'h0000_008F);
    bus_write(OFF_CTRL, 32'h0000_0001);
    $display("test xor register done");
  endtask : t_xor_work_with_reg

  task automatic t_tst;
    logic [15:0] nx [6] = '{16'h0000, 16'hC123, 16'hEC00, 16'hEE10, 16'hEF00, 16'hEB05};
    int cy [6] = '{2, 3, 3, 3, 3, 3};
    logic [31:0] p;
    bus_write(OFF_BSR, 32'h0000_0001);
    set_mem(8'h02, 8'h01);
    bus_write(OFF_WREG, 32'h0000_0000);
    run_op(16'h0A00, 16'h0000, 1);
    bus_read(OFF_PC, p);
    run_op(16'h6702, 16'h0000, 1);
    chk_reg("stat", OFF_STAT, stat(1, 0, 0, 0, 1));
    chk_reg("pc", OFF_PC, p + 32'h0000_0002);
    set_mem(8'h02, 8'h00);
    bus_write(OFF_WREG, 32'h0000_0080);
    run_op(16'h0A00, 16'h0000, 1);
    for (int i = 0; i < 6; i++) begin
      bus_read(OFF_PC, p);
      run_op(16'h6702, nx[i], cy[i]);
      chk_reg("stat", OFF_STAT, stat(cy[i], 1, 0, 1, 0));
      chk_reg("pc", OFF_PC, p + 2 * cy[i]);
    end
    // with the extended set off the move-to-pointer word is a single word
    bus_write(OFF_CTRL, 32'h0000_0000);
    run_op(16'h6702, 16'hEB05, 2);
    bus_write(OFF_CTRL, 32'h0000_0001);
    $display("test skip done");
  endtask : t_tst

  task automatic t_ext;
    bus_write(OFF_THIRD_POINTER_REG, 32'h0000_03FF);
    run_op(16'hE8A3, 16'h0000, 1);
    chk_reg("third_pointer_reg", OFF_THIRD_POINTER_REG, 32'h0000_0422);
    bus_write(OFF_FSR1, 32'h0000_0010);
    run_op(16'hE945, 16'h0000, 1);
    chk_reg("fsr1", OFF_FSR1, 32'h0000_000B);
    bus_write(OFF_TOS, 32'h0000_1234);
    run_op(16'hE8C4, 16'h0000, 2);
    chk_reg("third_pointer_reg", OFF_THIRD_POINTER_REG, 32'h0000_0426);
    chk_reg("pc", OFF_PC, 32'h0000_1234);
    bus_write(OFF_TOS, 32'h0000_0200);
    run_op(16'hE9C6, 16'h0000, 2);
    chk_reg("third_pointer_reg", OFF_THIRD_POINTER_REG, 32'h0000_0420);
    chk_reg("pc", OFF_PC, 32'h0000_0200);
    bus_write(OFF_CTRL, 32'h0000_0000);
    run_op(16'hE8A3, 16'h0000, 1);
    chk_reg("third_pointer_reg", OFF_THIRD_POINTER_REG, 32'h0000_0420);
    chk_reg("stat bad", OFF_STAT, stat(1, 0, 1, 1, 0));
    bus_write(OFF_CTRL, 32'h0000_0001);
    $display("test extended done");
  endtask : t_ext

  task automatic t_table_write_op;
    bus_write(OFF_TPTR, 32'h0000_A356);
    bus_write(OFF_TLAT, 32'h0000_0055);
    run_op(16'h000D, 16'h0000, 2);
    chk_reg("hold6", OFF_HOLD + 8'h18, 32'h0000_0055);
    chk_reg("tptr", OFF_TPTR, 32'h0000_A357);
    bus_write(OFF_TPTR, 32'h0001_389A);
    bus_write(OFF_TLAT, 32'h0000_0034);
    run_op(16'h000F, 16'h0000, 2);
    chk_reg("hold3", OFF_HOLD + 8'h0C, 32'h0000_0034);
    chk_reg("hold2", OFF_HOLD + 8'h08, 32'h0000_0000);
    chk_reg("tptr", OFF_TPTR, 32'h0001_389B);
    $display("test table write done");
  endtask : t_table_write_op

  // the whole sequence needs well under a thousand clocks; the 30000-clock margin is generous
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    bad_count = 0;
    comparisons = 0;
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_xor_literal_to_work();
    t_xor_work_with_reg();
    t_tst();
    t_ext();
    t_table_write_op();
    end_sim();
  end
endmodule : tsx_core_tb_top
